// >>> core/tc_regs.vh
// register map, field positions and key values of the touch controller host registers
// assumes inclusion by bare name from the design file; definitions only
`ifndef TC_REGS_VH
`define TC_REGS_VH

// register offsets on the register port
`define TC_A_IRQ        8'h00
`define TC_A_MODE       8'h09
`define TC_A_GPO        8'h0a
`define TC_A_PINSEL     8'h0b
`define TC_A_INTEN      8'h0c
`define TC_A_CFG        8'h0d
`define TC_A_BASE       8'h0e
`define TC_A_GSH        8'h10
`define TC_A_GSL        8'h11
`define TC_A_KEYH       8'hac
`define TC_A_KEYL       8'had
`define TC_A_SRST       8'hb1

// key and trigger values
`define TC_KEY_H        8'h62
`define TC_KEY_L        8'h9d
`define TC_BURN_1       8'ha5
`define TC_BURN_2       8'h5a
`define TC_SRST_1       8'hde
`define TC_SRST_2       8'h00

// mode_compensation_control fields
`define TC_MODE_ACTIVE  2'h0
`define TC_MODE_DOZE    2'h1
`define TC_MODE_SLEEP   2'h2
`define TC_MODE_RSVD    2'h3
`define TC_CMP_BIT      2

// param_memory_gateway_config fields
`define TC_GW_HI        5
`define TC_GW_LO        4
`define TC_DIR_BIT      3
`define TC_GW_NORMAL    2'h0
`define TC_GW_SPM       2'h1

// burst and memory geometry
`define TC_BASE_MASK    8'h78
`define TC_BURST_LAST   3'h7
`define TC_SPM_LAST     7'h7f
`define TC_GW_WINDOW    8'h07

// interrupt source and status bit positions
`define TC_IRQ_BURN     6
`define TC_IRQ_SPMW     5
`define TC_IRQ_COMP     1
`define TC_GSH_WDONE    6

// burn counter
`define TC_BURN_NONE    3'h0
`define TC_BURN_FALLBK  3'h4
`define TC_BURN_ONE     3'h1

// shadow memory locations of power-up parameters
`define TC_SPM_PWRUP    7'h40
`define TC_SPM_ON       7'h41
`define TC_SPM_OFF      7'h42

// factory default image, 128 bytes, byte 0 in the low bits
`define TC_FACTORY_IMAGE 1024'h0

// zero constants
`define TC_Z8           8'h00
`define TC_Z3           3'h0

`endif

// >>> core/tc_host_regs.v
// host-visible control registers of the touch controller: mode, outputs, soft reset, parameter gateway, burn
// assumes a register port already framed from the two-wire target (one strobe per byte) and one clock
//
// Operation
// - two-bit mode field: 00 active, 01 doze, 10 sleep, 11 reserved; reads show mode.
// - compensation bit reads one while running; writing one starts compensation.
// - host writes zeros to bits 7:3; device may return anything there.
// - on/off bits drive pins to on or off level when automatic lighting off.
// - on/off register powers up from the shadow memory power-up parameter.
// - three-bit pin select, reset zero, picks which pwm pin intensity accesses address.
// - intensity register holds selected pin intensity index; default from power-up on/off levels.
// - full chip reset only on 0xDE immediately followed by 0x00 write.
// - gateway config bits 5:4: 00 normal, 01 gateway mode, others reserved.
// - gateway config bit 3: zero bursts write memory, one bursts read it.
// - burst base is multiple of eight from 0x00 to 0x78, reset zero.
// - every gateway transfer moves exactly eight bytes from the programmed base.
// - write burst done raises interrupt; any read drops it and clears write-done flag.
// - read burst done also raises interrupt; any register read clears it.
// - burn count kept and shown in general status low bits 7:5.
// - each burn up to the fourth increments count; fourth burn falls back to factory defaults for good.
// - factory state: empty storage, count zero, shadow memory from factory defaults.
// - burn only after keys 0x62, 0x9D then 0xA5, 0x5A to base, ended by stop.
// - burn done sets source bit 6, write done bit 5; reading source clears.
`timescale 1ns/1ps
`default_nettype none
`include "tc_regs.vh"

module tc_host_regs (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        i2c_stop,
  input  wire        comp_done,
  input  wire        autolight_en,
  input  wire [7:0]  gpo_pin_mask,
  output reg  [7:0]  reg_rdata,
  output reg         interrupt_out_n,
  output reg  [1:0]  op_mode,
  output reg         comp_start,
  output reg  [63:0] gpo_level,
  output reg  [63:0] pwm_level,
  output reg         init_busy
);

  // sequencer states
  localparam [1:0] S_LOAD  = 2'b00;
  localparam [1:0] S_APPLY = 2'b01;
  localparam [1:0] S_RUN   = 2'b10;
  localparam [1:0] S_BURN  = 2'b11;

  // burn unlock states
  localparam [2:0] K_IDLE  = 3'b000;
  localparam [2:0] K_HIGH  = 3'b001;
  localparam [2:0] K_LOW   = 3'b010;
  localparam [2:0] K_TRIG1 = 3'b011;
  localparam [2:0] K_ARMED = 3'b100;

  reg  [7:0]    spm_mem [0:127];
  reg  [7:0]    nvm_mem [0:127];
  reg  [1:0]    seq_q;
  reg  [6:0]    idx_q;
  reg  [2:0]    key_q;
  reg  [2:0]    burn_cnt_q;
  reg           srst_armed_q;
  reg           srst_fire_q;
  reg           comp_run_q;
  reg  [7:0]    gpo_q;
  reg  [2:0]    pin_sel_q;
  reg  [1:0]    gw_mode_q;
  reg           gw_dir_q;
  reg  [7:0]    base_q;
  reg  [7:0]    keyh_q;
  reg  [7:0]    keyl_q;
  reg  [7:0]    srst_q;
  reg  [2:0]    gw_cnt_q;
  reg  [2:0]    irq_q;
  reg           wdone_q;
  reg  [7:0]    rd_mux;
  reg           pend_d;

  wire          chip_rst;
  wire          run;
  wire          acc_wr;
  wire          acc_rd;
  wire          gw_on;
  wire          gw_hit;
  wire [6:0]    gw_addr;
  wire          ev_spmw;
  wire          ev_spmr;
  wire          ev_burn;
  wire          ev_comp;
  wire          use_nvm;
  wire [1023:0] fac_img;
  wire [7:0]    load_byte;
  wire [7:0]    pwrup_v;
  wire [7:0]    on_lvl;
  wire [7:0]    off_lvl;

  // soft reset acts as a full chip reset but leaves the burn counter alone
  assign chip_rst  = sys_rst | srst_fire_q;
  assign run       = (seq_q == S_RUN);
  // accept only once busy has dropped, so the host sees the same window as the logic
  assign acc_wr    = reg_wr & run & ~init_busy;
  assign acc_rd    = reg_rd & run & ~init_busy;
  assign gw_on     = (gw_mode_q == `TC_GW_SPM);
  assign gw_hit    = gw_on & (reg_addr <= `TC_GW_WINDOW);
  assign gw_addr   = {base_q[6:3], reg_addr[2:0]};
  // burst completes only on its eighth byte
  assign ev_spmw   = acc_wr & gw_hit & ~gw_dir_q & (gw_cnt_q == `TC_BURST_LAST);
  assign ev_spmr   = acc_rd & gw_hit & gw_dir_q & (gw_cnt_q == `TC_BURST_LAST);
  assign ev_burn   = (seq_q == S_BURN) & (idx_q == `TC_SPM_LAST);
  assign ev_comp   = comp_done & comp_run_q;
  // counts one to three use the burned image, zero and four the factory one
  assign use_nvm   = (burn_cnt_q != `TC_BURN_NONE) & (burn_cnt_q != `TC_BURN_FALLBK);
  assign fac_img   = `TC_FACTORY_IMAGE;
  assign load_byte = use_nvm ? nvm_mem[idx_q] : fac_img[{idx_q, 3'b000} +: 8];
  assign pwrup_v   = spm_mem[`TC_SPM_PWRUP];
  assign on_lvl    = spm_mem[`TC_SPM_ON];
  assign off_lvl   = spm_mem[`TC_SPM_OFF];

  // load, apply, run, burn sequencer; register access only in run
  always @(posedge ref_clk) begin
    if (chip_rst) begin
      seq_q <= S_LOAD;
      idx_q <= 7'h00;
    end else begin
      case (seq_q)
        S_LOAD: begin
          idx_q <= idx_q + 7'h01;
          if (idx_q == `TC_SPM_LAST)
            seq_q <= S_APPLY;
        end
        S_APPLY: seq_q <= S_RUN;
        S_RUN: begin
          idx_q <= 7'h00;
          if ((key_q == K_ARMED) && i2c_stop)
            seq_q <= S_BURN;
        end
        S_BURN: begin
          idx_q <= idx_q + 7'h01;
          if (idx_q == `TC_SPM_LAST)
            seq_q <= S_RUN;
        end
        default: seq_q <= S_LOAD;
      endcase
    end
  end

  // shadow memory: filled at reset, then written only through the gateway
  always @(posedge ref_clk) begin
    if (seq_q == S_LOAD)
      spm_mem[idx_q] <= load_byte;
    else if (acc_wr && gw_hit && !gw_dir_q)
      spm_mem[gw_addr] <= reg_wdata;
  end

  // non-volatile copy; after fallback the copy is skipped, it is never read again
  always @(posedge ref_clk) begin
    if ((seq_q == S_BURN) && (burn_cnt_q != `TC_BURN_FALLBK))
      nvm_mem[idx_q] <= spm_mem[idx_q];
  end

  // burn counter survives soft reset; only power-up clears it
  always @(posedge ref_clk) begin
    if (sys_rst)
      burn_cnt_q <= `TC_BURN_NONE;
    else if (ev_burn && (burn_cnt_q != `TC_BURN_FALLBK))
      burn_cnt_q <= burn_cnt_q + `TC_BURN_ONE;
  end

  // burn unlock; a wrong value anywhere starts over, a first key restarts at step one
  always @(posedge ref_clk) begin
    if (chip_rst) begin
      key_q <= K_IDLE;
    end else if (seq_q == S_BURN) begin
      key_q <= K_IDLE;
    end else if (acc_wr) begin
      if ((reg_addr == `TC_A_KEYH) && (reg_wdata == `TC_KEY_H))
        key_q <= K_HIGH;
      else if ((key_q == K_HIGH) && (reg_addr == `TC_A_KEYL) && (reg_wdata == `TC_KEY_L))
        key_q <= K_LOW;
      else if ((key_q == K_LOW) && (reg_addr == `TC_A_BASE) && (reg_wdata == `TC_BURN_1))
        key_q <= K_TRIG1;
      else if ((key_q == K_TRIG1) && (reg_addr == `TC_A_BASE) && (reg_wdata == `TC_BURN_2))
        key_q <= K_ARMED;
      else
        key_q <= K_IDLE;
    end
  end

  // soft reset pair must be back to back on the trigger register
  always @(posedge ref_clk) begin
    if (chip_rst) begin
      srst_armed_q <= 1'b0;
      srst_fire_q  <= 1'b0;
    end else if (acc_wr) begin
      srst_armed_q <= (reg_addr == `TC_A_SRST) && (reg_wdata == `TC_SRST_1);
      srst_fire_q  <= srst_armed_q && (reg_addr == `TC_A_SRST) && (reg_wdata == `TC_SRST_2);
    end
  end

  // mode, compensation, gateway and plain storage registers
  always @(posedge ref_clk) begin
    if (chip_rst) begin
      op_mode    <= `TC_MODE_ACTIVE;
      comp_run_q <= 1'b0;
      comp_start <= 1'b0;
      pin_sel_q  <= `TC_Z3;
      gw_mode_q  <= `TC_GW_NORMAL;
      gw_dir_q   <= 1'b0;
      base_q     <= `TC_Z8;
      keyh_q     <= `TC_Z8;
      keyl_q     <= `TC_Z8;
      srst_q     <= `TC_Z8;
    end else begin
      comp_start <= acc_wr && (reg_addr == `TC_A_MODE) && reg_wdata[`TC_CMP_BIT];
      // a start request wins over a completion in the same cycle
      if (acc_wr && (reg_addr == `TC_A_MODE) && reg_wdata[`TC_CMP_BIT])
        comp_run_q <= 1'b1;
      else if (comp_done)
        comp_run_q <= 1'b0;
      if (acc_wr) begin
        case (reg_addr)
          `TC_A_MODE: begin
            // reserved code is refused so the mode always reads back a legal value
            if (reg_wdata[1:0] != `TC_MODE_RSVD)
              op_mode <= reg_wdata[1:0];
          end
          `TC_A_PINSEL: pin_sel_q <= reg_wdata[2:0];
          `TC_A_CFG: begin
            gw_mode_q <= reg_wdata[`TC_GW_HI:`TC_GW_LO];
            gw_dir_q  <= reg_wdata[`TC_DIR_BIT];
          end
          `TC_A_BASE: base_q <= reg_wdata & `TC_BASE_MASK;
          `TC_A_KEYH: keyh_q <= reg_wdata;
          `TC_A_KEYL: keyl_q <= reg_wdata;
          `TC_A_SRST: srst_q <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // burst byte counter restarts whenever config or base is rewritten
  always @(posedge ref_clk) begin
    if (chip_rst)
      gw_cnt_q <= `TC_Z3;
    else if (acc_wr && ((reg_addr == `TC_A_CFG) || (reg_addr == `TC_A_BASE)))
      gw_cnt_q <= `TC_Z3;
    else if ((acc_wr && gw_hit && !gw_dir_q) || (acc_rd && gw_hit && gw_dir_q))
      gw_cnt_q <= gw_cnt_q + 3'h1;
  end

  // on/off register: powered up from shadow memory, then host writable
  always @(posedge ref_clk) begin
    if (chip_rst)
      gpo_q <= `TC_Z8;
    else if (seq_q == S_APPLY)
      gpo_q <= pwrup_v;
    else if (acc_wr && !gw_hit && (reg_addr == `TC_A_GPO))
      gpo_q <= reg_wdata;
  end

  // per-pin intensity index and on/off level drive
  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_pin
      always @(posedge ref_clk) begin
        if (chip_rst)
          pwm_level[k*8 +: 8] <= `TC_Z8;
        else if (seq_q == S_APPLY)
          pwm_level[k*8 +: 8] <= pwrup_v[k] ? on_lvl : off_lvl;
        else if (acc_wr && !gw_hit && (reg_addr == `TC_A_INTEN) && (pin_sel_q == k))
          pwm_level[k*8 +: 8] <= reg_wdata;
      end
      // pins not configured as on/off keep their level; autolight owns them when on
      always @(posedge ref_clk) begin
        if (chip_rst)
          gpo_level[k*8 +: 8] <= `TC_Z8;
        else if (!autolight_en && gpo_pin_mask[k] && run)
          gpo_level[k*8 +: 8] <= gpo_q[k] ? on_lvl : off_lvl;
      end
    end
  endgenerate

  // interrupt pending: events set, any read clears, set wins
  always @* begin
    pend_d = ~interrupt_out_n;
    if (acc_rd)
      pend_d = 1'b0;
    if (ev_spmw || ev_spmr || ev_burn || ev_comp)
      pend_d = 1'b1;
  end

  // source flags and write-done; reading the source register clears it, events win
  always @(posedge ref_clk) begin
    if (chip_rst) begin
      interrupt_out_n <= 1'b1;
      irq_q           <= `TC_Z3;
      wdone_q         <= 1'b0;
    end else begin
      interrupt_out_n <= ~pend_d;
      if (acc_rd && !gw_hit && (reg_addr == `TC_A_IRQ))
        irq_q <= {ev_burn, ev_spmw, ev_comp};
      else
        irq_q <= irq_q | {ev_burn, ev_spmw, ev_comp};
      if (ev_spmw)
        wdone_q <= 1'b1;
      else if (acc_rd)
        wdone_q <= 1'b0;
    end
  end

  // read data select; reserved bits read as zero
  always @* begin
    rd_mux = `TC_Z8;
    if (gw_hit)
      rd_mux = gw_dir_q ? spm_mem[gw_addr] : `TC_Z8;
    else begin
      case (reg_addr)
        `TC_A_IRQ:    rd_mux = {1'b0, irq_q[2], irq_q[1], 3'b000, irq_q[0], 1'b0};
        `TC_A_MODE:   rd_mux = {5'b00000, comp_run_q, op_mode};
        `TC_A_GPO:    rd_mux = gpo_q;
        `TC_A_PINSEL: rd_mux = {5'b00000, pin_sel_q};
        `TC_A_INTEN:  rd_mux = pwm_level[{pin_sel_q, 3'b000} +: 8];
        `TC_A_CFG:    rd_mux = {2'b00, gw_mode_q, gw_dir_q, 3'b000};
        `TC_A_BASE:   rd_mux = base_q;
        `TC_A_GSH:    rd_mux = {1'b0, wdone_q, 6'b000000};
        `TC_A_GSL:    rd_mux = {burn_cnt_q, 5'b00000};
        `TC_A_KEYH:   rd_mux = keyh_q;
        `TC_A_KEYL:   rd_mux = keyl_q;
        `TC_A_SRST:   rd_mux = srst_q;
        default:      rd_mux = `TC_Z8;
      endcase
    end
  end

  // read data and busy flag from flops
  always @(posedge ref_clk) begin
    if (chip_rst) begin
      reg_rdata <= `TC_Z8;
      init_busy <= 1'b1;
    end else begin
      init_busy <= ~run;
      if (acc_rd)
        reg_rdata <= rd_mux;
    end
  end

endmodule // tc_host_regs

`default_nettype wire

// >>> tb/tc_regs_checker.sv
// assertion checker for the touch controller host register block
// assumes a bind onto tc_host_regs, one clock ref_clk, sync reset sys_rst
`timescale 1ns/1ps
`default_nettype none
`include "tc_regs.vh"

module tc_regs_checker (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        i2c_stop,
  input wire logic        autolight_en,
  input wire logic [1:0]  op_mode,
  input wire logic        comp_start,
  input wire logic [63:0] gpo_level,
  input wire logic [63:0] pwm_level,
  input wire logic        init_busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // accepted writes; busy cycles drop every access
  wire wr_ok   = reg_wr && !init_busy;
  wire wr_mode = wr_ok && reg_addr == `TC_A_MODE;
  wire wr_srst = wr_ok && reg_addr == `TC_A_SRST;

  property p_comp_start; wr_mode && reg_wdata[`TC_CMP_BIT] |=> comp_start || init_busy; endproperty
  a_comp_start: assert property (p_comp_start) else $error("compensation start missing");
  property p_comp_cause; comp_start |-> $past(wr_mode && reg_wdata[`TC_CMP_BIT]); endproperty
  a_comp_cause: assert property (p_comp_cause) else $error("compensation start without write");
  property p_mode_set; wr_mode && reg_wdata[1:0] != `TC_MODE_RSVD |=> op_mode == $past(reg_wdata[1:0]) || init_busy;
  endproperty
  a_mode_set: assert property (p_mode_set) else $error("mode not taken");
  property p_mode_rsvd; wr_mode && reg_wdata[1:0] == `TC_MODE_RSVD |=> $stable(op_mode) || init_busy; endproperty
  a_mode_rsvd: assert property (p_mode_rsvd) else $error("reserved mode applied");
  property p_mode_legal; op_mode != `TC_MODE_RSVD; endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("mode shows reserved code");
  // automatic lighting owns the pins, so the register must not move them
  property p_gpo_hold; autolight_en && !init_busy |=> $stable(gpo_level) || init_busy; endproperty
  a_gpo_hold: assert property (p_gpo_hold) else $error("on/off level moved under autolight");
  property p_pwm_hold; !init_busy && !(wr_ok && reg_addr == `TC_A_INTEN) |=> $stable(pwm_level) || init_busy;
  endproperty
  a_pwm_hold: assert property (p_pwm_hold) else $error("intensity moved without write");
  // the host leaves one idle cycle between its writes
  property p_srst; wr_srst && reg_wdata == `TC_SRST_1 ##1 !reg_wr ##1 wr_srst && reg_wdata == `TC_SRST_2
    |-> ##[1:3] init_busy; endproperty
  a_srst: assert property (p_srst) else $error("soft reset not performed");
  // busy may only rise two edges after a write (soft reset) or a stop (burn)
  property p_quiet; $rose(init_busy) |-> $past(reg_wr, 2) || $past(i2c_stop, 2); endproperty
  a_quiet: assert property (p_quiet) else $error("busy without cause");
endmodule // tc_regs_checker

bind tc_host_regs tc_regs_checker u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .i2c_stop(i2c_stop), .autolight_en(autolight_en),
  .op_mode(op_mode), .comp_start(comp_start), .gpo_level(gpo_level), .pwm_level(pwm_level),
  .init_busy(init_busy));

`default_nettype wire

// >>> tb/tc_host_model.sv
// host controller model driving the framed register port
// assumes callers run in the ref_clk domain; one access at a time
`timescale 1ns/1ps
`default_nettype none

module tc_host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       i2c_stop
);
  // idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    i2c_stop = 1'b0;
  end

  // released lines show inverted values so stale data is never trusted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // callers read only once busy is low, so no settle wait
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask

  // stop condition ends a write transaction
  task automatic stop;
    @(posedge ref_clk);
    i2c_stop <= 1'b1;
    @(posedge ref_clk);
    i2c_stop <= 1'b0;
  endtask
endmodule // tc_host_model

`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the touch controller host registers
// assumes the host model and checker files compiled before this one
`timescale 1ns/1ps
`default_nettype none
`include "tc_regs.vh"

module tb_top;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        comp_done = 1'b0;
  logic        autolight_en = 1'b0;
  logic [7:0]  gpo_pin_mask = 8'h0f;
  wire logic   reg_wr;
  wire logic   reg_rd;
  wire logic [7:0] reg_addr;
  wire logic [7:0] reg_wdata;
  wire logic   i2c_stop;
  wire logic [7:0] reg_rdata;
  wire logic   interrupt_out_n;
  wire logic [1:0] op_mode;
  wire logic   comp_start;
  wire logic [63:0] gpo_level;
  wire logic [63:0] pwm_level;
  wire logic   init_busy;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;

  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;

  tc_host_model host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .i2c_stop(i2c_stop));

  tc_host_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .i2c_stop(i2c_stop), .comp_done(comp_done), .autolight_en(autolight_en),
    .gpo_pin_mask(gpo_pin_mask), .reg_rdata(reg_rdata), .interrupt_out_n(interrupt_out_n), .op_mode(op_mode),
    .comp_start(comp_start), .gpo_level(gpo_level), .pwm_level(pwm_level), .init_busy(init_busy));

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // hang guard, well above the roughly 1200 cycles the run needs
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk($sformatf("register %h", a), e, d);
  endtask

  // busy may start a cycle or two late, so give it a moment first
  task automatic idle_wait;
    int n;
    n = 0;
    repeat (3) @(posedge ref_clk);
    while (init_busy !== 1'b0 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    chk("init_busy", 64'h0, init_busy);
  endtask

  task automatic burn;
    host.wr(`TC_A_KEYH, `TC_KEY_H);
    host.wr(`TC_A_KEYL, `TC_KEY_L);
    host.wr(`TC_A_BASE, `TC_BURN_1);
    host.wr(`TC_A_BASE, `TC_BURN_2);
    host.stop();
    idle_wait();
  endtask

  task automatic srst;
    host.wr(`TC_A_SRST, `TC_SRST_1);
    host.wr(`TC_A_SRST, `TC_SRST_2);
    idle_wait();
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // burst pattern: power-up state, on level, off level, then filler
  function automatic logic [7:0] pat(input int i);
    case (i)
      0: pat = 8'h5a;
      1: pat = 8'hc8;
      2: pat = 8'h11;
      default: pat = 8'(8'h30 + i);
    endcase
  endfunction

  // main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    idle_wait();
    rdc(`TC_A_MODE, 8'h00);
    rdc(`TC_A_GPO, 8'h00);
    rdc(`TC_A_PINSEL, 8'h00);
    rdc(`TC_A_INTEN, 8'h00);
    rdc(`TC_A_BASE, 8'h00);
    rdc(`TC_A_GSL, 8'h00);
    rdc(8'h55, 8'h00);
    done("reset values");
    for (int m = 0; m < 3; m++) begin
      host.wr(`TC_A_MODE, 8'(m));
      @(posedge ref_clk);
      chk("op_mode", m, op_mode);
    end
    host.wr(`TC_A_MODE, {6'h00, `TC_MODE_RSVD});
    @(posedge ref_clk);
    chk("op_mode", 64'h2, op_mode);
    host.wr(`TC_A_MODE, 8'h06);
    @(negedge ref_clk);
    chk("comp_start", 64'h1, comp_start);
    rdc(`TC_A_MODE, 8'h06);
    comp_done <= 1'b1;
    @(posedge ref_clk);
    comp_done <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("interrupt_out_n", 64'h0, interrupt_out_n);
    rdc(`TC_A_IRQ, 8'h02);
    rdc(`TC_A_MODE, 8'h02);
    chk("interrupt_out_n", 64'h1, interrupt_out_n);
    done("mode and compensation");
    host.wr(`TC_A_CFG, 8'h10);
    host.wr(`TC_A_BASE, 8'h40);
    for (int i = 0; i < 8; i++) host.wr(8'(i), pat(i));
    repeat (2) @(posedge ref_clk);
    chk("interrupt_out_n", 64'h0, interrupt_out_n);
    host.wr(`TC_A_CFG, 8'h00);
    rdc(`TC_A_GSH, 8'h40);
    chk("interrupt_out_n", 64'h1, interrupt_out_n);
    rdc(`TC_A_GSH, 8'h00);
    rdc(`TC_A_IRQ, 8'h20);
    rdc(`TC_A_IRQ, 8'h00);
    host.wr(`TC_A_GPO, 8'h05);
    repeat (2) @(posedge ref_clk);
    chk("gpo_level", 64'h11c811c8, gpo_level);
    autolight_en <= 1'b1;
    host.wr(`TC_A_GPO, 8'hff);
    repeat (2) @(posedge ref_clk);
    chk("gpo_level", 64'h11c811c8, gpo_level);
    autolight_en <= 1'b0;
    host.wr(`TC_A_CFG, 8'h18);
    host.wr(`TC_A_BASE, 8'h47);
    for (int i = 0; i < 8; i++) rdc(8'(i), pat(i));
    chk("interrupt_out_n", 64'h0, interrupt_out_n);
    host.wr(`TC_A_CFG, 8'h00);
    rdc(`TC_A_IRQ, 8'h00);
    chk("interrupt_out_n", 64'h1, interrupt_out_n);
    done("gateway bursts");
    host.wr(`TC_A_PINSEL, 8'h03);
    host.wr(`TC_A_SRST, `TC_SRST_1);
    host.wr(`TC_A_SRST, 8'h01);
    host.wr(`TC_A_SRST, `TC_SRST_2);
    repeat (4) @(posedge ref_clk);
    chk("init_busy", 64'h0, init_busy);
    rdc(`TC_A_PINSEL, 8'h03);
    host.wr(`TC_A_KEYH, `TC_KEY_H);
    host.wr(`TC_A_BASE, `TC_BURN_1);
    host.wr(`TC_A_KEYL, `TC_KEY_L);
    host.wr(`TC_A_BASE, `TC_BURN_1);
    host.wr(`TC_A_BASE, `TC_BURN_2);
    host.stop();
    repeat (4) @(posedge ref_clk);
    chk("init_busy", 64'h0, init_busy);
    burn();
    chk("interrupt_out_n", 64'h0, interrupt_out_n);
    rdc(`TC_A_IRQ, 8'h40);
    rdc(`TC_A_GSL, 8'h20);
    srst();
    rdc(`TC_A_GPO, 8'h5a);
    chk("pwm_level", 64'h11c811c8c811c811, pwm_level);
    rdc(`TC_A_INTEN, 8'h11);
    host.wr(`TC_A_PINSEL, 8'h07);
    host.wr(`TC_A_INTEN, 8'h9e);
    rdc(`TC_A_INTEN, 8'h9e);
    chk("pwm_level", 8'h9e, pwm_level[63:56]);
    for (int b = 2; b < 5; b++) begin
      burn();
      rdc(`TC_A_GSL, 8'(b << 5));
    end
    srst();
    rdc(`TC_A_GPO, 8'h00);
    rdc(`TC_A_GSL, 8'h80);
    done("soft reset and burn");
    finish_test();
  end
endmodule // tb_top

`default_nettype wire
